// ### rtl/ctcm_cfg.svh
`ifndef CTCM_CFG_SVH
`define CTCM_CFG_SVH
// Coprocessor register numbers
`define CTCM_CRN_CACHEOP 4'h7
`define CTCM_CRN_LOCK 4'h9
`define CTCM_CRN_PROCID 4'hd
`define CTCM_CRN_TEST 4'hf
// CRm codes for registers 7, 9, 13 and 15
`define CTCM_CRM_WAIT 4'h0
`define CTCM_CRM_IFLUSH 4'h5
`define CTCM_CRM_DFLUSH 4'h6
`define CTCM_CRM_DCLEAN 4'ha
`define CTCM_CRM_IPREF 4'hd
`define CTCM_CRM_DCLFL 4'he
`define CTCM_CRM_WAIT_ALT 4'h8
`define CTCM_CRM_LOCK 4'h0
`define CTCM_CRM_REGION 4'h1
`define CTCM_CRM_PID0 4'h0
`define CTCM_CRM_PID1 4'h1
// Opcode_2 codes
`define CTCM_OP2_ALL 3'h0
`define CTCM_OP2_ADDR 3'h1
`define CTCM_OP2_INDEX 3'h2
`define CTCM_OP2_DRAIN 3'h4
`define CTCM_OP2_WAIT 3'h4
`define CTCM_OP2_WAIT_ALT 3'h2
// Field positions
`define CTCM_LOCK_LOAD_BIT 31
`define CTCM_SEG_HI 1
`define CTCM_BASE_HI 31
`define CTCM_BASE_LO 12
`define CTCM_SIZE_HI 5
`define CTCM_SIZE_LO 1
`define CTCM_INDEX_LO 5
`define CTCM_INDEX_HI_MIN 9
`define CTCM_INDEX_HI_MAX 17
`define CTCM_SIZE_4KB 5'h03
`define CTCM_SIZE_4GB 5'h17
`define CTCM_SIZE_LOG_OFS 5'h09
`define CTCM_BASE_RST 20'h0_0000
`endif

// ### rtl/ctcm_pkg.sv
package ctcm_pkg;
   typedef struct packed {
      logic valid;
      logic write;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] op2;
      logic [31:0] data;
   } ctcm_req_t;
   typedef enum logic [2:0] {
      CTCM_NONE, CTCM_IINV_ALL, CTCM_IINV_ADDR, CTCM_IPREF, CTCM_DINV_ALL,
      CTCM_DINV_ADDR, CTCM_DCLEAN, CTCM_DCLFL
   } ctcm_op_t;
   typedef struct packed {
      ctcm_op_t op;
      logic byIndex;
      logic [31:0] addr;
   } ctcm_cmd_t;
   typedef enum {CTCM_RUN, CTCM_HOLD, CTCM_DRAIN, CTCM_WFI} ctcm_state_t;
endpackage

// ### rtl/ctcm_sync2.sv
`timescale 1ns/100ps
module ctcm_sync2 (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic asyncIn,
   output logic syncOut
);
   logic meta_r;
   // Two stages; only the second is visible
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         meta_r <= asyncIn;
         syncOut <= meta_r;
      end
   end
endmodule

// ### rtl/ctcm_regs.sv
`timescale 1ns/100ps
`include "ctcm_cfg.svh"
// Behaviour
// - c5 invalidates icache all or by address
// - c13 op2 1 prefetches icache line
// - c6 invalidates dcache all or by address
// - c10 cleans, c14 cleans and invalidates
// - Index field starts bit 5, size-dependent top
// - Maintenance waits for running linefetch
// - Drain stalls core until buffer empty
// - Two encodings enter wait-for-interrupt
// - Interrupts or debug request end waiting
// - Debug wake needs debug enable
// - Wake reason steers interrupt or debug entry
// - Write buffer drains during wait
// - Lock registers: load bit, segment field
// - Region registers: base and area size
// - Size code 3 is 4KB, doubling
// - Larger area aliases physical memory
// - Instruction region base reads zero
// - Reset clears base, loads physical size
// - Overlap sends data writes, and data reads outside load mode, to instruction memory
// - Process ID readable, driven to pins
module ctcm_regs import ctcm_pkg::*; (
   input wire logic core_clk,
   input wire logic resetn,
   input ctcm_req_t req,
   output logic [31:0] readData,
   output logic stallCore,
   output ctcm_cmd_t cacheCmd,
   input wire logic cacheBusy,
   input wire logic linefetchBusy,
   input wire logic writeBufEmpty,
   output logic lowPower,
   output logic takeIrqFirst,
   output logic enterDebug,
   input wire logic fast_interrupt_request_n,
   input wire logic normal_interrupt_request_n,
   input wire logic external_debug_request,
   input wire logic debug_enable_input,
   input wire logic debugReqBit,
   input wire logic [4:0] dataPhysSize,
   input wire logic [4:0] instPhysSize,
   input wire logic [3:0] indexTopSel,
   input wire logic [31:0] dataAccAddr,
   input wire logic instLoadMode,
   output logic dataToInstRead,
   output logic dataToInstWrite,
   output logic [31:0] trace_process_id_out,
   output logic [31:0] dataCacheLock,
   output logic [31:0] instCacheLock,
   output logic [31:0] dataRegion,
   output logic [31:0] instRegion
);
   ////////////////////////////////////////////////////////////////////////
   logic fiqS, irqS, dbgS, dbgEnS;
   ctcm_sync2 uFiq (.core_clk(core_clk), .resetn(resetn),
      .asyncIn(~fast_interrupt_request_n), .syncOut(fiqS));
   ctcm_sync2 uIrq (.core_clk(core_clk), .resetn(resetn),
      .asyncIn(~normal_interrupt_request_n), .syncOut(irqS));
   ctcm_sync2 uDbg (.core_clk(core_clk), .resetn(resetn),
      .asyncIn(external_debug_request), .syncOut(dbgS));
   ctcm_sync2 uDen (.core_clk(core_clk), .resetn(resetn),
      .asyncIn(debug_enable_input), .syncOut(dbgEnS));

   ////////////////////////////////////////////////////////////////////////
   // Decode of writes to registers 7, 9, 13 and 15
   logic wr7, wr9, wr13;
   ctcm_op_t opDec;
   logic opByIndex;
   logic drainReq, wfiReq;
   assign wr7 = req.valid && req.write && (req.crn == `CTCM_CRN_CACHEOP);
   assign wr9 = req.valid && req.write && (req.crn == `CTCM_CRN_LOCK);
   assign wr13 = req.valid && req.write && (req.crn == `CTCM_CRN_PROCID)
      && (req.crm == `CTCM_CRM_PID0 || req.crm == `CTCM_CRM_PID1)
      && (req.op2 == `CTCM_OP2_ADDR);
   assign drainReq = wr7 && req.crm == `CTCM_CRM_DCLEAN
      && req.op2 == `CTCM_OP2_DRAIN;
   assign wfiReq = (wr7 && req.crm == `CTCM_CRM_WAIT && req.op2 == `CTCM_OP2_WAIT)
      || (req.valid && req.write && req.crn == `CTCM_CRN_TEST
      && req.crm == `CTCM_CRM_WAIT_ALT && req.op2 == `CTCM_OP2_WAIT_ALT);

   always_comb begin
      opDec = CTCM_NONE;
      opByIndex = 1'b0;
      if (wr7) begin
         case (req.crm)
            `CTCM_CRM_IFLUSH: begin
               if (req.op2 == `CTCM_OP2_ALL) opDec = CTCM_IINV_ALL;
               else if (req.op2 == `CTCM_OP2_ADDR) opDec = CTCM_IINV_ADDR;
            end
            `CTCM_CRM_IPREF: begin
               if (req.op2 == `CTCM_OP2_ADDR) opDec = CTCM_IPREF;
            end
            `CTCM_CRM_DFLUSH: begin
               if (req.op2 == `CTCM_OP2_ALL) opDec = CTCM_DINV_ALL;
               else if (req.op2 == `CTCM_OP2_ADDR) opDec = CTCM_DINV_ADDR;
            end
            `CTCM_CRM_DCLEAN, `CTCM_CRM_DCLFL: begin
               if (req.op2 == `CTCM_OP2_ADDR || req.op2 == `CTCM_OP2_INDEX) begin
                  opDec = (req.crm == `CTCM_CRM_DCLEAN) ? CTCM_DCLEAN : CTCM_DCLFL;
                  opByIndex = (req.op2 == `CTCM_OP2_INDEX);
               end
            end
            default: opDec = CTCM_NONE;
         endcase
      end
   end

   // Index top bit grows one per cache size doubling
   logic [31:0] idxMask;
   logic [4:0] idxTop;
   assign idxTop = 5'(`CTCM_INDEX_HI_MIN) + {1'b0, indexTopSel};
   // Select codes past the largest cache saturate instead of eating tag bits
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         idxMask[i] = (i >= `CTCM_INDEX_LO && i <= int'(idxTop)
            && i <= `CTCM_INDEX_HI_MAX) || (i <= `CTCM_SEG_HI);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   ctcm_state_t state_r;
   ctcm_cmd_t pend_r;
   logic wakeIrq;
   logic wakeDbg;
   assign wakeIrq = fiqS || irqS;
   assign wakeDbg = dbgEnS && (dbgS || debugReqBit);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= CTCM_RUN;
         pend_r <= '0;
         cacheCmd <= '0;
         stallCore <= 1'b0;
         lowPower <= 1'b0;
         takeIrqFirst <= 1'b0;
         enterDebug <= 1'b0;
      end else begin
         cacheCmd <= '0;
         takeIrqFirst <= 1'b0;
         enterDebug <= 1'b0;
         case (state_r)
            CTCM_RUN: begin
               if (opDec != CTCM_NONE) begin
                  pend_r.op <= opDec;
                  pend_r.byIndex <= opByIndex;
                  pend_r.addr <= opByIndex ? (req.data & idxMask) : req.data;
                  stallCore <= 1'b1;
                  state_r <= CTCM_HOLD;
               end else if (drainReq) begin
                  stallCore <= 1'b1;
                  state_r <= CTCM_DRAIN;
               end else if (wfiReq) begin
                  stallCore <= 1'b1;
                  lowPower <= 1'b1;
                  state_r <= CTCM_WFI;
               end
            end
            CTCM_HOLD: begin
               // Issuing mid-linefill would corrupt the refilled line
               if (!linefetchBusy && !cacheBusy) begin
                  cacheCmd <= pend_r;
                  stallCore <= 1'b0;
                  state_r <= CTCM_RUN;
               end
            end
            CTCM_DRAIN: begin
               if (writeBufEmpty) begin
                  stallCore <= 1'b0;
                  state_r <= CTCM_RUN;
               end
            end
            CTCM_WFI: begin
               // Buffer keeps draining; its state machine is not gated here
               if (wakeIrq || wakeDbg) begin
                  stallCore <= 1'b0;
                  lowPower <= 1'b0;
                  takeIrqFirst <= wakeIrq && !wakeDbg;
                  enterDebug <= wakeDbg;
                  state_r <= CTCM_RUN;
               end
            end
            default: state_r <= CTCM_RUN;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lock and region registers
   logic physLoaded_r;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dataCacheLock <= 32'h0000_0000;
         instCacheLock <= 32'h0000_0000;
         dataRegion <= 32'h0000_0000;
         instRegion <= 32'h0000_0000;
         physLoaded_r <= 1'b0;
      end else begin
         if (!physLoaded_r) begin
            // Size straps captured after release, base stays zero
            physLoaded_r <= 1'b1;
            dataRegion[`CTCM_SIZE_HI:`CTCM_SIZE_LO] <= dataPhysSize;
            instRegion[`CTCM_SIZE_HI:`CTCM_SIZE_LO] <= instPhysSize;
         end else if (wr9 && req.crm == `CTCM_CRM_LOCK) begin
            if (req.op2 == `CTCM_OP2_ALL) begin
               dataCacheLock[`CTCM_LOCK_LOAD_BIT] <= req.data[`CTCM_LOCK_LOAD_BIT];
               dataCacheLock[`CTCM_SEG_HI:0] <= req.data[`CTCM_SEG_HI:0];
            end else if (req.op2 == `CTCM_OP2_ADDR) begin
               instCacheLock[`CTCM_LOCK_LOAD_BIT] <= req.data[`CTCM_LOCK_LOAD_BIT];
               instCacheLock[`CTCM_SEG_HI:0] <= req.data[`CTCM_SEG_HI:0];
            end
         end else if (wr9 && req.crm == `CTCM_CRM_REGION) begin
            if (req.op2 == `CTCM_OP2_ALL) begin
               dataRegion[`CTCM_BASE_HI:`CTCM_BASE_LO]
                  <= req.data[`CTCM_BASE_HI:`CTCM_BASE_LO];
               dataRegion[`CTCM_SIZE_HI:`CTCM_SIZE_LO]
                  <= req.data[`CTCM_SIZE_HI:`CTCM_SIZE_LO];
            end else if (req.op2 == `CTCM_OP2_ADDR) begin
               // Base is hardwired; nonzero writes are software's fault
               instRegion[`CTCM_SIZE_HI:`CTCM_SIZE_LO]
                  <= req.data[`CTCM_SIZE_HI:`CTCM_SIZE_LO];
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) trace_process_id_out <= 32'h0000_0000;
      else if (wr13) trace_process_id_out <= req.data;
   end

   ////////////////////////////////////////////////////////////////////////
   // Area decode: size code 3 is 4KB, so mask width is code + 9 bits
   function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
      logic [5:0] lg;
      logic [31:0] m;
      lg = {1'b0, r[`CTCM_SIZE_HI:`CTCM_SIZE_LO]} + {1'b0, `CTCM_SIZE_LOG_OFS};
      m = (lg >= 6'd32) ? 32'h0000_0000 : ~((32'h0000_0001 << lg) - 32'h0000_0001);
      // Upper address bits only: smaller memory aliases inside the area
      hit = ((a & m) == (r & m));
   endfunction

   logic inD, inI;
   assign inD = hit(dataAccAddr, dataRegion);
   assign inI = hit(dataAccAddr, instRegion);
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dataToInstRead <= 1'b0;
         dataToInstWrite <= 1'b0;
      end else begin
         dataToInstRead <= inI && !(inD && instLoadMode);
         dataToInstWrite <= inI;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) readData <= 32'h0000_0000;
      else if (req.valid && !req.write) begin
         readData <= 32'h0000_0000;
         if (req.crn == `CTCM_CRN_LOCK && req.crm == `CTCM_CRM_LOCK) begin
            if (req.op2 == `CTCM_OP2_ALL) readData <= dataCacheLock;
            else if (req.op2 == `CTCM_OP2_ADDR) readData <= instCacheLock;
         end else if (req.crn == `CTCM_CRN_LOCK && req.crm == `CTCM_CRM_REGION) begin
            if (req.op2 == `CTCM_OP2_ALL) readData <= dataRegion;
            else if (req.op2 == `CTCM_OP2_ADDR) readData <= instRegion;
         end else if (req.crn == `CTCM_CRN_PROCID && (req.crm == `CTCM_CRM_PID0
            || req.crm == `CTCM_CRM_PID1) && req.op2 == `CTCM_OP2_ADDR) begin
            readData <= trace_process_id_out;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   chk_drain_hold: assert property (@(posedge core_clk) disable iff (!resetn)
      (state_r == CTCM_DRAIN && !writeBufEmpty) |=> stallCore)
      else $error("Drain released stall early");
   chk_maint_wait: assert property (@(posedge core_clk) disable iff (!resetn)
      (cacheCmd.op != CTCM_NONE) |-> $past(!linefetchBusy))
      else $error("Maintenance issued during linefetch");
   chk_wfi_enter: assert property (@(posedge core_clk) disable iff (!resetn)
      (state_r == CTCM_RUN && wfiReq && opDec == CTCM_NONE && !drainReq)
      |=> (lowPower && stallCore))
      else $error("Wait not entered");
   chk_wfi_wake: assert property (@(posedge core_clk) disable iff (!resetn)
      (state_r == CTCM_WFI && wakeIrq) |=> (!stallCore && !lowPower))
      else $error("Interrupt did not wake");
   chk_dbg_gate: assert property (@(posedge core_clk) disable iff (!resetn)
      enterDebug |-> $past(dbgEnS))
      else $error("Debug wake without enable");
   chk_irq_first: assert property (@(posedge core_clk) disable iff (!resetn)
      takeIrqFirst |-> ($past(wakeIrq) && !enterDebug))
      else $error("Interrupt flag without cause");
   chk_ibase_zero: assert property (@(posedge core_clk) disable iff (!resetn)
      instRegion[`CTCM_BASE_HI:`CTCM_BASE_LO] == `CTCM_BASE_RST)
      else $error("Instruction base not zero");
   chk_pid_pins: assert property (@(posedge core_clk) disable iff (!resetn)
      wr13 |=> (trace_process_id_out == $past(req.data)))
      else $error("Process id not driven");
   chk_ignore_op: assert property (@(posedge core_clk) disable iff (!resetn)
      (state_r == CTCM_RUN && wr7 && opDec == CTCM_NONE && !drainReq && !wfiReq)
      |=> (!stallCore && cacheCmd.op == CTCM_NONE))
      else $error("Unlisted operation acted");
endmodule

// ### testbench/ctcm_far_model.sv
`timescale 1ns/100ps
module ctcm_far_model import ctcm_pkg::*; (
   input wire logic core_clk,
   input wire logic resetn,
   input ctcm_cmd_t cacheCmd,
   input wire logic lfStart,
   input wire logic [3:0] wbLoad,
   output logic cacheBusy,
   output logic linefetchBusy,
   output logic writeBufEmpty
);
   logic [3:0] lfCnt_r;
   logic [3:0] wbCnt_r;
   logic [1:0] busyCnt_r;
   ////////////////////////////////////////////////////////////
   // Linefetch holds for five cycles once started
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         lfCnt_r <= 4'h0;
      end else if (lfStart) begin
         lfCnt_r <= 4'h5;
      end else if (lfCnt_r != 4'h0) begin
         lfCnt_r <= lfCnt_r - 4'h1;
      end
   end
   // Buffer retires one entry a cycle, core halted or not
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wbCnt_r <= 4'h0;
      end else if (wbLoad != 4'h0) begin
         wbCnt_r <= wbLoad;
      end else if (wbCnt_r != 4'h0) begin
         wbCnt_r <= wbCnt_r - 4'h1;
      end
   end
   // Array stays busy after each command, so back-to-back ops must wait
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         busyCnt_r <= 2'h0;
      end else if (cacheCmd.op != CTCM_NONE) begin
         busyCnt_r <= 2'h2;
      end else if (busyCnt_r != 2'h0) begin
         busyCnt_r <= busyCnt_r - 2'h1;
      end
   end
   ////////////////////////////////////////////////////////////
   assign linefetchBusy = (lfCnt_r != 4'h0);
   assign writeBufEmpty = (wbCnt_r == 4'h0);
   assign cacheBusy = (busyCnt_r != 2'h0);
endmodule

// ### testbench/ctcm_regs_tb.sv
`timescale 1ns/100ps
module ctcm_regs_tb;
   import ctcm_pkg::*;
   logic core_clk, resetn, stallCore, cacheBusy, linefetchBusy, writeBufEmpty, lowPower;
   logic takeIrqFirst, enterDebug, fast_interrupt_request_n, normal_interrupt_request_n;
   logic external_debug_request, debug_enable_input, debugReqBit, instLoadMode, lfStart;
   logic dataToInstRead, dataToInstWrite, a, b;
   logic [4:0] dataPhysSize, instPhysSize;
   logic [3:0] indexTopSel;
   logic [3:0] wbLoad;
   logic [31:0] readData, dataAccAddr, trace_process_id_out, dataCacheLock, instCacheLock;
   logic [31:0] dataRegion, instRegion, d;
   ctcm_req_t req;
   ctcm_cmd_t cacheCmd;
   int error_cnt = 0;
   int checks_done = 0;
   logic [3:0] opCrm [9] = '{4'h5, 4'h5, 4'hd, 4'h6, 4'h6, 4'ha, 4'he, 4'ha, 4'he};
   logic [2:0] opSel [9] = '{3'h0, 3'h1, 3'h1, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2};
   ctcm_op_t opExp [9] = '{CTCM_IINV_ALL, CTCM_IINV_ADDR, CTCM_IPREF, CTCM_DINV_ALL,
      CTCM_DINV_ADDR, CTCM_DCLEAN, CTCM_DCLFL, CTCM_DCLEAN, CTCM_DCLFL};
   ctcm_regs ctcm_regs_i (.core_clk, .resetn, .req, .readData, .stallCore, .cacheCmd,
      .cacheBusy, .linefetchBusy, .writeBufEmpty, .lowPower, .takeIrqFirst, .enterDebug,
      .fast_interrupt_request_n, .normal_interrupt_request_n, .external_debug_request,
      .debug_enable_input, .debugReqBit, .dataPhysSize, .instPhysSize, .indexTopSel,
      .dataAccAddr, .instLoadMode, .dataToInstRead, .dataToInstWrite, .trace_process_id_out,
      .dataCacheLock, .instCacheLock, .dataRegion, .instRegion);
   ctcm_far_model ctcm_far_model_i (.core_clk, .resetn, .cacheCmd, .lfStart, .wbLoad,
      .cacheBusy, .linefetchBusy, .writeBufEmpty);
   always #20 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cpAcc(input logic wr, input logic [3:0] crn, input logic [3:0] crm,
         input logic [2:0] op2, input logic [31:0] dat);
      @(posedge core_clk);
      req <= '{1'b1, wr, crn, crm, op2, dat};
      @(posedge core_clk);
      req <= '0;
   endtask
   task automatic cpRd(input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2,
         input logic [31:0] exp, input string what);
      cpAcc(1'b0, crn, crm, op2, 32'h0000_0000);
      @(posedge core_clk);
      #1;
      check(what, readData, exp);
   endtask
   // Bounded wait for the one-cycle command pulse
   task automatic cacheOp(input logic [3:0] crm, input logic [2:0] op2, input logic [31:0] dat);
      int n;
      cpAcc(1'b1, 4'h7, crm, op2, dat);
      for (n = 0; n < 40 && cacheCmd.op === CTCM_NONE; n++) begin
         @(posedge core_clk);
         #1;
      end
      check("lf idle at cmd", 32'(linefetchBusy), 32'h0);
   endtask
   task automatic wake(input logic [3:0] src, output logic irq, output logic dbg);
      irq = 1'b0;
      dbg = 1'b0;
      @(posedge core_clk);
      fast_interrupt_request_n <= !src[3];
      normal_interrupt_request_n <= !src[2];
      external_debug_request <= src[1];
      debugReqBit <= src[0];
      repeat (8) begin
         @(posedge core_clk);
         #1;
         irq = irq | takeIrqFirst;
         dbg = dbg | enterDebug;
      end
      {fast_interrupt_request_n, normal_interrupt_request_n} <= 2'b11;
      {external_debug_request, debugReqBit} <= 2'b00;
      repeat (5) @(posedge core_clk);
   endtask
   task automatic route(input logic [31:0] addr, input logic ld, input logic [1:0] exp);
      @(posedge core_clk);
      dataAccAddr <= addr;
      instLoadMode <= ld;
      repeat (2) @(posedge core_clk);
      #1;
      check("route", 32'({dataToInstRead, dataToInstWrite}), 32'(exp));
   endtask
   task automatic loadBuf();
      @(posedge core_clk);
      wbLoad <= 4'h6;
      @(posedge core_clk);
      wbLoad <= 4'h0;
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      #400000;
      error_cnt++;
      summarize();
   end
   initial begin
      {core_clk, resetn, req, lfStart, wbLoad, instLoadMode, debugReqBit} = '0;
      {fast_interrupt_request_n, normal_interrupt_request_n, debug_enable_input} = 3'b111;
      {external_debug_request, dataAccAddr, indexTopSel} = '0;
      dataPhysSize = 5'h05;
      instPhysSize = 5'h04;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge core_clk);
      indexTopSel <= 4'h2;
      cpRd(4'h9, 4'h1, 3'h0, 32'h0000_000a, "data region reset");
      cpRd(4'h9, 4'h1, 3'h1, 32'h0000_0008, "inst region reset");
      for (int i = 0; i < 2; i++) begin
         cpAcc(1'b1, 4'h9, 4'h0, 3'(i), 32'hffff_ffff);
         cpRd(4'h9, 4'h0, 3'(i), 32'h8000_0003, "lock reg");
      end
      check("inst lock out", instCacheLock, 32'h8000_0003);
      check("data lock out", dataCacheLock, 32'h8000_0003);
      cpAcc(1'b1, 4'h9, 4'h1, 3'h0, 32'h1230_0017);
      cpRd(4'h9, 4'h1, 3'h0, 32'h1230_0016, "data region");
      check("data region out", dataRegion, 32'h1230_0016);
      // Instruction side written with a zero base; only the size field lands
      cpAcc(1'b1, 4'h9, 4'h1, 3'h1, 32'h0000_0fef);
      cpRd(4'h9, 4'h1, 3'h1, 32'h0000_002e, "inst region");
      check("inst region out", instRegion, 32'h0000_002e);
      cpAcc(1'b1, 4'hd, 4'h0, 3'h1, 32'hcafe_f00d);
      // Pins update on the edge that ends the write; look once they settle
      #1;
      check("pid pins", trace_process_id_out, 32'hcafe_f00d);
      cpRd(4'hd, 4'h1, 3'h1, 32'hcafe_f00d, "pid alias");
      cpAcc(1'b1, 4'h9, 4'h1, 3'h1, 32'h0000_0006);
      cpAcc(1'b1, 4'h9, 4'h1, 3'h0, 32'h0000_0008);
      route(32'h0000_0ffc, 1'b0, 2'b11);
      route(32'h0000_0ffc, 1'b1, 2'b01);
      route(32'h0000_1000, 1'b0, 2'b00);
      @(posedge core_clk);
      lfStart <= 1'b1;
      @(posedge core_clk);
      lfStart <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         d = (opSel[i] == 3'h2) ? 32'h0000_3fe0 : ((opSel[i] == 3'h1) ? 32'h0000_1240 : '0);
         cacheOp(opCrm[i], opSel[i], d);
         check("cmd op", 32'(cacheCmd.op), 32'(opExp[i]));
         check("cmd idx", 32'(cacheCmd.byIndex), 32'(opSel[i] == 3'h2));
         check("cmd addr", cacheCmd.addr, (opSel[i] == 3'h2) ? 32'h0000_0fe0 : d);
      end
      cpAcc(1'b1, 4'h7, 4'h3, 3'h0, 32'h0000_0000);
      repeat (4) begin
         @(posedge core_clk);
         #1;
         check("ignored op", 32'({stallCore, cacheCmd.op}), 32'h0);
      end
      loadBuf();
      cpAcc(1'b1, 4'h7, 4'ha, 3'h4, 32'h0000_0000);
      #1;
      check("drain stall", 32'(stallCore), 32'h1);
      for (int n = 0; n < 30 && stallCore === 1'b1; n++) @(posedge core_clk) #1;
      check("drain empty", 32'(writeBufEmpty), 32'h1);
      cpAcc(1'b1, 4'h7, 4'h0, 3'h4, 32'h0000_0000);
      repeat (2) @(posedge core_clk);
      #1;
      check("wait entry", 32'({lowPower, stallCore}), 32'h3);
      wake(4'b0100, a, b);
      check("irq wake", 32'({lowPower, a, b}), 32'h2);
      debug_enable_input <= 1'b0;
      cpAcc(1'b1, 4'hf, 4'h8, 3'h2, 32'h0000_0000);
      repeat (2) @(posedge core_clk);
      #1;
      check("alt entry", 32'(lowPower), 32'h1);
      wake(4'b0011, a, b);
      check("debug gated", 32'({lowPower, a, b}), 32'h4);
      debug_enable_input <= 1'b1;
      wake(4'b0010, a, b);
      check("debug wake", 32'({lowPower, a, b}), 32'h1);
      loadBuf();
      cpAcc(1'b1, 4'h7, 4'h0, 3'h4, 32'h0000_0000);
      repeat (10) @(posedge core_clk);
      #1;
      check("drain in wait", 32'({lowPower, writeBufEmpty}), 32'h3);
      wake(4'b1000, a, b);
      check("fiq wake", 32'({lowPower, a, b}), 32'h2);
      cpAcc(1'b1, 4'h7, 4'h0, 3'h4, 32'h0000_0000);
      wake(4'b0001, a, b);
      check("bit wake", 32'({lowPower, a, b}), 32'h1);
      summarize();
   end
endmodule
